// ===== dtc_pkg.sv
// shared constants and types for the dual down-counter timer
package dtc_pkg;

    // base clock and selectable source rates
    localparam int unsigned CLK_FREQ_KHZ = 100000;
    localparam int unsigned SRC_RATE0_KHZ = 26000;
    localparam int unsigned SRC_RATE1_KHZ = 13000;
    localparam int unsigned SRC_RATE2_KHZ = 6500;
    localparam int unsigned SRC_RATE3_KHZ = 3250;
    localparam int unsigned SRC_ACC_W = 17;

    // prescale terminal counts: divide by 1, 16, 256
    localparam logic [7:0] PRE_LIM_DIV1 = 8'h00;
    localparam logic [7:0] PRE_LIM_DIV16 = 8'h0f;
    localparam logic [7:0] PRE_LIM_DIV256 = 8'hff;

    localparam logic [31:0] CNT_MAX_32 = 32'hffffffff;
    localparam logic [31:0] CNT_MAX_16 = 32'h0000ffff;

    // register offsets within one counter's bank
    localparam logic [4:0] OFS_LOAD = 5'h00;
    localparam logic [4:0] OFS_VALUE = 5'h04;
    localparam logic [4:0] OFS_CTRL = 5'h08;
    localparam logic [4:0] OFS_CLR = 5'h0c;
    localparam logic [4:0] OFS_RAW = 5'h10;
    localparam logic [4:0] OFS_MASKED = 5'h14;
    localparam logic [4:0] OFS_BGLOAD = 5'h18;
    // bank bases and shared registers
    localparam logic [7:0] BANK_ONE = 8'h00;
    localparam logic [7:0] BANK_TWO = 8'h20;
    localparam logic [7:0] ADDR_GATE = 8'h40;
    localparam logic [7:0] ADDR_SRC = 8'h44;
    localparam int unsigned BANK_BIT = 5;

    // control field layout, bit 7 down to bit 0
    typedef struct packed {
        logic enable;
        logic periodic;
        logic irq_en;
        logic spare;
        logic [1:0] prescale;
        logic wide;
        logic single;
    } dtc_ctrl_s;

    localparam logic [7:0] CTRL_RESET = 8'h20;
    localparam logic [1:0] GATE_RESET = 2'h0;
    localparam logic [1:0] SRC_RESET = 2'h0;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        CNT_ACTIVE = 2'b01,
        CNT_HALTED = 2'b10
    } dtc_cnt_e;

endpackage

// ===== dtc_srcgen.sv
// common source tick generator, fractional rate from the system clock
`timescale 1ns/1ps
`default_nettype none
module dtc_srcgen (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [1:0] src_sel,
    output logic src_tick_q
);
    localparam int unsigned AW = dtc_pkg::SRC_ACC_W;
    logic [AW-1:0] acc_q;
    logic [AW-1:0] inc;
    logic [AW:0] sum;

    always_comb
    begin
        unique case (src_sel)
            2'b00: inc = AW'(dtc_pkg::SRC_RATE0_KHZ); // RL1
            2'b01: inc = AW'(dtc_pkg::SRC_RATE1_KHZ);
            2'b10: inc = AW'(dtc_pkg::SRC_RATE2_KHZ);
            2'b11: inc = AW'(dtc_pkg::SRC_RATE3_KHZ);
        endcase
    end

    assign sum = {1'b0, acc_q} + {1'b0, inc};

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            acc_q <= '0;
            src_tick_q <= 1'b0;
        end
        else if (sum >= (AW+1)'(dtc_pkg::CLK_FREQ_KHZ))
        begin
            acc_q <= AW'(sum - (AW+1)'(dtc_pkg::CLK_FREQ_KHZ));
            src_tick_q <= 1'b1;
        end
        else
        begin
            acc_q <= AW'(sum);
            src_tick_q <= 1'b0;
        end
    end

    a_tick_spacing: assert property (@(posedge clk) disable iff (!arst_n)
        src_tick_q |=> !src_tick_q) // RL1
        else $error("source tick closer than two cycles");
endmodule
`default_nettype wire

// ===== dtc_counter.sv
// one down-counter with its prescaler, reload and expiry flag
`timescale 1ns/1ps
`default_nettype none
module dtc_counter (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic src_tick,
    input wire dtc_pkg::dtc_ctrl_s ctrl,
    input wire logic gate,
    input wire logic load_wr,
    input wire logic bg_wr,
    input wire logic clr_wr,
    input wire logic [31:0] wr_data,
    output logic [31:0] count_q,
    output logic [31:0] reload_q,
    output logic raw_q
);
    dtc_pkg::dtc_cnt_e state_q;
    logic [7:0] pre_q;
    logic [7:0] pre_lim;
    logic [31:0] max_v;
    logic [31:0] cur;
    logic run;
    logic tick;
    logic zero;
    logic at_one;
    logic expire;

    always_comb
    begin
        unique case (ctrl.prescale)
            2'b00: pre_lim = dtc_pkg::PRE_LIM_DIV1; // RL3
            2'b01: pre_lim = dtc_pkg::PRE_LIM_DIV16; // RL4
            2'b10, 2'b11: pre_lim = dtc_pkg::PRE_LIM_DIV256; // RL4
        endcase
    end

    assign max_v = ctrl.wide ? dtc_pkg::CNT_MAX_32 : dtc_pkg::CNT_MAX_16; // RL12 RL13
    assign cur = count_q & max_v;
    assign zero = (cur == 32'h0);
    assign at_one = (cur == 32'h1);
    assign run = ctrl.enable && gate && (state_q == dtc_pkg::CNT_ACTIVE); // RL19
    assign tick = run && src_tick && (pre_q >= pre_lim); // RL2
    assign expire = tick && (at_one || (zero && ctrl.single)); // RL21

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            pre_q <= 8'h00;
        else if (src_tick)
            pre_q <= (pre_q >= pre_lim) ? 8'h00 : pre_q + 8'h01; // RL2
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            state_q <= dtc_pkg::CNT_ACTIVE;
        else
        begin
            unique case (state_q)
                dtc_pkg::CNT_ACTIVE:
                    if (expire && ctrl.single && !load_wr)
                        state_q <= dtc_pkg::CNT_HALTED; // RL9 RL15
                dtc_pkg::CNT_HALTED:
                    if (load_wr || !ctrl.single)
                        state_q <= dtc_pkg::CNT_ACTIVE; // RL10 RL11
                default:
                    state_q <= dtc_pkg::CNT_ACTIVE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            count_q <= 32'h0;
        else if (load_wr)
            count_q <= wr_data & max_v; // RL18 RL24
        else if (tick)
        begin
            if (zero && !ctrl.single)
                count_q <= ctrl.periodic ? (reload_q & max_v) : max_v; // RL7 RL8 RL16
            else if (!zero)
                count_q <= cur - 32'h1; // RL17
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            reload_q <= 32'h0;
        else if (load_wr || bg_wr)
            reload_q <= wr_data; // RL25
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            raw_q <= 1'b0;
        else
            raw_q <= expire || (raw_q && !clr_wr); // RL21 RL22
    end

    a_wrap_free: assert property (@(posedge clk) disable iff (!arst_n) // RL7
        tick && zero && !ctrl.single && !ctrl.periodic && !load_wr |=> count_q == $past(max_v))
        else $error("free-running counter did not wrap to maximum");
    a_periodic_reload: assert property (@(posedge clk) disable iff (!arst_n) // RL8
        tick && zero && !ctrl.single && ctrl.periodic && !load_wr |=> count_q == $past(reload_q & max_v))
        else $error("periodic counter did not reload");
    a_oneshot_halt: assert property (@(posedge clk) disable iff (!arst_n) // RL9
        expire && ctrl.single && !load_wr ##1 ctrl.single && !load_wr
        |=> !run ##1 ($stable(count_q) || $past(load_wr)))
        else $error("one-shot counter kept running after zero");
    a_stopped_holds: assert property (@(posedge clk) disable iff (!arst_n) // RL19
        !(ctrl.enable && gate) && !load_wr |=> $stable(count_q))
        else $error("counter moved while not enabled");
    c_oneshot_stop: cover property (@(posedge clk) disable iff (!arst_n)
        expire && ctrl.single);
endmodule
`default_nettype wire

// ===== dtc_top.sv
// dual down-counter timer: axi4-lite register slave and two counters
//
// Contract
// RL1 - one two-bit field picks shared source rate
// RL2 - each counter prescales the source to ticks
// RL3 - prescale zero divides by one
// RL4 - prescale one/16, two/256, three/256
// RL5 - software enables clock gate before configuring
// RL6 - reset: interrupt enable set, rest zero
// RL7 - free-running default; wraps to maximum, flags
// RL8 - periodic mode reloads from reload value
// RL9 - one-shot flags once then halts
// RL10 - clearing one-shot bit resumes halted counter
// RL11 - reload write restarts one-shot counter
// RL12 - width bit selects 16 or 32 bits
// RL13 - width bit one means 32 bits
// RL14 - single-run and reload-mode bits choose mode
// RL15 - single-run bit one forces one-shot
// RL16 - reload mode zero free, one periodic
// RL17 - decrement by one per tick
// RL18 - reload write also loads current count
// RL19 - count needs run bit and gate bit
// RL20 - interrupt enable lets expiry reach masked
// RL21 - raw set always; masked is raw and enable
// RL22 - any clear-register write clears expiry
// RL23 - both masked expiries share one line
// RL24 - reload write restarts running counter immediately
// RL25 - background write changes reload only
//
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module dtc_top (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic irq
);
    dtc_pkg::dtc_ctrl_s ctrl_q [2];
    logic [1:0] gate_q;
    logic [1:0] src_q;
    logic [31:0] count [2];
    logic [31:0] reload [2];
    logic [1:0] raw;
    logic [1:0] masked;
    logic [1:0] load_wr;
    logic [1:0] bg_wr;
    logic [1:0] clr_wr;
    logic [1:0] wr_bank;
    logic [31:0] wr_load [2];
    logic [31:0] wr_bg [2];
    logic [31:0] wr_val [2];
    logic src_tick;
    logic wr_fire;
    logic rd_fire;
    logic wr_hit;
    logic rd_hit;
    logic [4:0] wr_ofs;
    logic [4:0] rd_ofs;
    logic rd_bank;
    logic [31:0] rd_word;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    localparam int unsigned BANK_BIT_L = dtc_pkg::BANK_BIT;
    localparam logic [7:0] BANK_ONE = dtc_pkg::BANK_ONE;
    localparam logic [7:0] BANK_TWO = dtc_pkg::BANK_TWO;

    // byte-lane merge for a partial write
    function automatic logic [31:0] dtc_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
                res[8*b +: 8] = nw[8*b +: 8];
        end
        return res;
    endfunction

    // write channel: both address and data must be offered before either is taken
    assign wr_fire = awvalid && wvalid && !bvalid_q;
    assign awready = wr_fire;
    assign wready = wr_fire;
    assign wr_ofs = {awaddr[4:2], 2'b00};
    assign wr_bank[0] = (awaddr[7:6] == 2'b00) && (awaddr[BANK_BIT_L] == BANK_ONE[BANK_BIT_L]);
    assign wr_bank[1] = (awaddr[7:6] == 2'b00) && (awaddr[BANK_BIT_L] == BANK_TWO[BANK_BIT_L]);
    assign wr_hit = ((awaddr[7:6] == 2'b00) && (wr_ofs <= dtc_pkg::OFS_BGLOAD))
        || ({awaddr[7:2], 2'b00} == dtc_pkg::ADDR_GATE)
        || ({awaddr[7:2], 2'b00} == dtc_pkg::ADDR_SRC);

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= dtc_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR;
        end
        else if (bready)
            bvalid_q <= 1'b0;
    end

    assign bvalid = bvalid_q;
    assign bresp = bresp_q;

    // read channel: one read outstanding, data registered
    assign rd_fire = arvalid && !rvalid_q;
    assign arready = !rvalid_q;
    assign rd_ofs = {araddr[4:2], 2'b00};
    assign rd_bank = araddr[BANK_BIT_L];

    always_comb
    begin
        rd_word = 32'h0;
        rd_hit = 1'b1;
        if (araddr[7:6] == 2'b00)
        begin
            unique case (rd_ofs)
                dtc_pkg::OFS_LOAD: rd_word = reload[rd_bank];
                dtc_pkg::OFS_VALUE: rd_word = count[rd_bank];
                dtc_pkg::OFS_CTRL: rd_word = {24'h0, ctrl_q[rd_bank]};
                dtc_pkg::OFS_CLR: rd_word = 32'h0;
                dtc_pkg::OFS_RAW: rd_word = {31'h0, raw[rd_bank]};
                dtc_pkg::OFS_MASKED: rd_word = {31'h0, masked[rd_bank]};
                dtc_pkg::OFS_BGLOAD: rd_word = reload[rd_bank];
                default: rd_hit = 1'b0;
            endcase
        end
        else if ({araddr[7:2], 2'b00} == dtc_pkg::ADDR_GATE)
            rd_word = {30'h0, gate_q};
        else if ({araddr[7:2], 2'b00} == dtc_pkg::ADDR_SRC)
            rd_word = {30'h0, src_q};
        else
            rd_hit = 1'b0;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= dtc_pkg::RESP_OKAY;
        end
        else if (rd_fire)
        begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_hit ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR;
        end
        else if (rready)
            rvalid_q <= 1'b0;
    end

    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

    // shared gate and source select
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            gate_q <= dtc_pkg::GATE_RESET; // RL6
        else if (wr_fire && wstrb[0] && {awaddr[7:2], 2'b00} == dtc_pkg::ADDR_GATE)
            gate_q <= wdata[1:0]; // RL19
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            src_q <= dtc_pkg::SRC_RESET; // RL6
        else if (wr_fire && wstrb[0] && {awaddr[7:2], 2'b00} == dtc_pkg::ADDR_SRC)
            src_q <= wdata[1:0]; // RL1
    end

    dtc_srcgen u_srcgen (
        .clk(clk),
        .arst_n(arst_n),
        .src_sel(src_q),
        .src_tick_q(src_tick)
    );

    for (genvar i = 0; i < 2; i++)
    begin : g_cnt
        // per-counter control register, mode bits read by the counter
        always_ff @(posedge clk or negedge arst_n)
        begin
            if (!arst_n)
                ctrl_q[i] <= dtc_pkg::CTRL_RESET; // RL6
            else if (wr_fire && wr_bank[i] && wstrb[0] && wr_ofs == dtc_pkg::OFS_CTRL)
                ctrl_q[i] <= wdata[7:0]; // RL14
        end

        assign load_wr[i] = wr_fire && wr_bank[i] && (wr_ofs == dtc_pkg::OFS_LOAD) && (wstrb != 4'h0);
        assign bg_wr[i] = wr_fire && wr_bank[i] && (wr_ofs == dtc_pkg::OFS_BGLOAD) && (wstrb != 4'h0);
        assign clr_wr[i] = wr_fire && wr_bank[i] && (wr_ofs == dtc_pkg::OFS_CLR); // RL22
        assign wr_load[i] = dtc_merge(reload[i], wdata, wstrb);
        assign wr_bg[i] = dtc_merge(reload[i], wdata, wstrb);
        assign wr_val[i] = load_wr[i] ? wr_load[i] : wr_bg[i];

        dtc_counter u_cnt (
            .clk(clk),
            .arst_n(arst_n),
            .src_tick(src_tick),
            .ctrl(ctrl_q[i]),
            .gate(gate_q[i]),
            .load_wr(load_wr[i]),
            .bg_wr(bg_wr[i]),
            .clr_wr(clr_wr[i]),
            .wr_data(wr_val[i]),
            .count_q(count[i]),
            .reload_q(reload[i]),
            .raw_q(raw[i])
        );

        assign masked[i] = raw[i] && ctrl_q[i].irq_en; // RL20 RL21
    end

    assign irq = |masked; // RL23

    // assertions
    a_irq_follows_raw: assert property (@(posedge clk) disable iff (!arst_n) // RL23
        $rose(raw[0]) && ctrl_q[0].irq_en || $rose(raw[1]) && ctrl_q[1].irq_en |-> irq)
        else $error("enabled expiry did not raise the interrupt");
    a_masked_off: assert property (@(posedge clk) disable iff (!arst_n) // RL20
        !ctrl_q[0].irq_en && !ctrl_q[1].irq_en |-> !irq)
        else $error("interrupt raised with both enables clear");
    // an expiry in the clear cycle wins, so cycles that may expire are left out
    a_clear_drops: assert property (@(posedge clk) disable iff (!arst_n) // RL22
        clr_wr[0] && !(count[0][15:0] <= 16'h1 && ctrl_q[0].enable && gate_q[0])
        |=> !raw[0] && !masked[0])
        else $error("masked status left set after clear");
    a_clear_raw: assert property (@(posedge clk) disable iff (!arst_n) // RL22
        clr_wr[1] && !(count[1][15:0] <= 16'h1 && ctrl_q[1].enable && gate_q[1])
        |=> !raw[1])
        else $error("raw status not cleared by clear write");
    a_load_copies: assert property (@(posedge clk) disable iff (!arst_n) // RL18
        load_wr[0] && wstrb == 4'hf |=> count[0] == ($past(wdata) & (ctrl_q[0].wide ? 32'hffffffff : 32'h0000ffff)))
        else $error("reload write did not set current count");
    a_bg_untouched: assert property (@(posedge clk) disable iff (!arst_n) // RL25
        bg_wr[0] && !(ctrl_q[0].enable && gate_q[0]) |=> $stable(count[0]))
        else $error("background write changed current count");
    a_write_answer: assert property (@(posedge clk) disable iff (!arst_n)
        wr_fire |=> bvalid ##0 !awready)
        else $error("write not answered in one cycle");
    a_read_hold: assert property (@(posedge clk) disable iff (!arst_n)
        rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped before taken");
    c_irq_rise: cover property (@(posedge clk) disable iff (!arst_n) $rose(irq));
    c_periodic_expiry: cover property (@(posedge clk) disable iff (!arst_n)
        $rose(raw[1]) && ctrl_q[1].periodic);
    c_bg_then_expiry: cover property (@(posedge clk) disable iff (!arst_n)
        bg_wr[0] ##[1:1000] $rose(raw[0]));
endmodule
`default_nettype wire

// ===== dtc_tb.sv
// self-checking bench for the dual down-counter timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin fail_count++; \
    $display("unexpected %s exp %h got %h", nm, ex, got); end end
module testbench;
    typedef struct {
        logic w;
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] e;
        logic [1:0] r;
    } dtc_row_s;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    logic irq;
    int fail_count = 0;
    int n_tests = 0;
    logic [31:0] rd;
    logic [1:0] rs;
    // source, prescale, lowest and highest count about 200 cycles after a reload of 1000
    int unsigned spd [7][4] = '{'{0, 0, 935, 960}, '{0, 1, 993, 998}, '{0, 2, 999, 1000}, '{0, 3, 999, 1000},
        '{1, 0, 966, 978}, '{2, 0, 982, 990}, '{3, 0, 990, 996}};
    dtc_row_s rows [19] = '{
        '{1'b0, 8'h08, 32'h0, 32'h20, 2'h0},
        '{1'b0, 8'h28, 32'h0, 32'h20, 2'h0},
        '{1'b0, 8'h00, 32'h0, 32'h0, 2'h0},
        '{1'b0, 8'h24, 32'h0, 32'h0, 2'h0},
        '{1'b0, 8'h40, 32'h0, 32'h0, 2'h0},
        '{1'b0, 8'h44, 32'h0, 32'h0, 2'h0},
        '{1'b0, 8'h10, 32'h0, 32'h0, 2'h0},
        '{1'b0, 8'h34, 32'h0, 32'h0, 2'h0},
        '{1'b1, 8'h00, 32'h1234, 32'h0, 2'h0},
        '{1'b0, 8'h04, 32'h0, 32'h1234, 2'h0},
        '{1'b1, 8'h18, 32'habcd, 32'h0, 2'h0},
        '{1'b0, 8'h04, 32'h0, 32'h1234, 2'h0},
        '{1'b0, 8'h00, 32'h0, 32'habcd, 2'h0},
        '{1'b1, 8'h44, 32'h3, 32'h0, 2'h0},
        '{1'b0, 8'h44, 32'h0, 32'h3, 2'h0},
        '{1'b1, 8'h4c, 32'hff, 32'h0, 2'h2},
        '{1'b0, 8'h4c, 32'h0, 32'h0, 2'h2},
        '{1'b0, 8'h0c, 32'h0, 32'h0, 2'h0},
        '{1'b1, 8'h40, 32'h3, 32'h0, 2'h0}};

    always #5 clk = ~clk;

    dtc_top u_dut (.clk(clk), .arst_n(arst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq));

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        @(negedge clk);
        while (awready !== 1'b1) @(negedge clk);
        @(posedge clk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        @(negedge clk);
        while (bvalid !== 1'b1) @(negedge clk);
        rs = bresp;
        @(posedge clk);
        bready <= 1'b0;
    endtask

    task automatic bus_rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        @(negedge clk);
        while (arready !== 1'b1) @(negedge clk);
        @(posedge clk);
        arvalid <= 1'b0;
        @(negedge clk);
        while (rvalid !== 1'b1) @(negedge clk);
        rd = rdata;
        rs = rresp;
        @(posedge clk);
        rready <= 1'b0;
    endtask

    // poll a raw status until set, then settle a few ticks
    task automatic wait_raw(input logic [7:0] a);
        int k;
        for (k = 0; k < 300 && rd !== 32'h1; k++)
            bus_rd(a);
        `CHK("raw expiry", 32'h1, rd)
        rd = 32'h0;
        repeat (8) @(posedge clk);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        repeat (40000) @(posedge clk);
        fail_count++;
        wrap_up();
    end

    initial
    begin
        rd = 32'h0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        foreach (rows[i])
        begin
            if (rows[i].w)
            begin
                bus_wr(rows[i].a, rows[i].d);
                `CHK("bresp", rows[i].r, rs)
            end
            else
            begin
                bus_rd(rows[i].a);
                `CHK("rdata", rows[i].e, rd)
                `CHK("rresp", rows[i].r, rs)
            end
        end
        // tick rate per source and prescale choice
        foreach (spd[i])
        begin
            bus_wr(8'h44, 32'(spd[i][0]));
            bus_wr(8'h08, 32'h80 | (32'(spd[i][1]) << 2));
            bus_wr(8'h00, 32'd1000);
            repeat (200) @(posedge clk);
            bus_rd(8'h04);
            `CHK("count window", 1'b1, rd >= 32'(spd[i][2]) && rd <= 32'(spd[i][3]))
        end
        bus_wr(8'h44, 32'h0);
        // free-running wrap in both widths
        for (int i = 0; i < 2; i++)
        begin
            bus_wr(8'h0c, 32'h0);
            bus_wr(8'h08, 32'ha0 | (32'(i) << 1));
            bus_wr(8'h00, 32'h3);
            wait_raw(8'h10);
            bus_rd(8'h04);
            `CHK("wrapped", 1'b1, rd > (i ? 32'hffffff00 : 32'h0000ff00) && rd <= (i ? 32'hffffffff : 32'h0000ffff))
            bus_rd(8'h14);
            `CHK("masked", 32'h1, rd)
            @(negedge clk);
            `CHK("irq", 1'b1, irq)
            bus_wr(8'h0c, 32'h0);
            bus_rd(8'h10);
            `CHK("raw cleared", 32'h0, rd)
            @(negedge clk);
            `CHK("irq cleared", 1'b0, irq)
        end
        // periodic on counter two with its interrupt masked
        bus_wr(8'h28, 32'hc0);
        bus_wr(8'h20, 32'h6);
        wait_raw(8'h30);
        bus_rd(8'h24);
        `CHK("periodic reload", 1'b1, rd >= 32'h1 && rd <= 32'h6)
        bus_rd(8'h34);
        `CHK("masked off", 32'h0, rd)
        bus_wr(8'h2c, 32'h0);
        bus_wr(8'h38, 32'h40);
        wait_raw(8'h30);
        bus_rd(8'h24);
        `CHK("background reload", 1'b1, rd >= 32'h38 && rd <= 32'h40)
        bus_wr(8'h28, 32'h20);
        // one-shot halts, restarts on reload, resumes when single cleared
        bus_wr(8'h0c, 32'h0);
        bus_wr(8'h08, 32'he1);
        bus_wr(8'h00, 32'h4);
        wait_raw(8'h10);
        repeat (40) @(posedge clk);
        bus_rd(8'h04);
        `CHK("one-shot halt", 32'h0, rd)
        bus_wr(8'h0c, 32'h0);
        bus_wr(8'h00, 32'h30);
        bus_rd(8'h04);
        `CHK("one-shot restart", 1'b1, rd >= 32'h28 && rd <= 32'h30)
        wait_raw(8'h10);
        repeat (40) @(posedge clk);
        bus_rd(8'h04);
        `CHK("halted again", 32'h0, rd)
        bus_wr(8'h08, 32'ha0);
        repeat (20) @(posedge clk);
        bus_rd(8'h04);
        `CHK("resumed free", 1'b1, rd > 32'h0000ff00 && rd <= 32'h0000ffff)
        // gate bit and run bit both needed
        bus_wr(8'h40, 32'h2);
        bus_wr(8'h08, 32'h80);
        bus_wr(8'h00, 32'h50);
        repeat (100) @(posedge clk);
        bus_rd(8'h04);
        `CHK("gated off", 32'h50, rd)
        bus_wr(8'h08, 32'h00);
        bus_wr(8'h40, 32'h3);
        repeat (100) @(posedge clk);
        bus_rd(8'h04);
        `CHK("run bit off", 32'h50, rd)
        bus_wr(8'h08, 32'h80);
        repeat (100) @(posedge clk);
        bus_rd(8'h04);
        `CHK("both on", 1'b1, rd < 32'h50)
        // reset in mid-run with a count running and an expiry pending
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        bus_rd(8'h08);
        `CHK("ctrl after reset", 32'h20, rd)
        bus_rd(8'h04);
        `CHK("count after reset", 32'h0, rd)
        bus_rd(8'h10);
        `CHK("raw after reset", 32'h0, rd)
        wrap_up();
    end
endmodule
`default_nettype wire
